// ---- hw/opcode_decoder.sv ----
// Native-mode first opcode decoder with operand address forming
`timescale 1ns/1ps
module opcode_decoder
	import decode_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Instruction bytes from fetch
	input wire logic inst_valid_in,
	input wire logic [7:0] first_byte_in,
	input wire logic [7:0] second_byte_in,
	input wire logic [7:0] disp_lo_in,
	input wire logic [7:0] disp_hi_in,
	input wire logic [7:0] imm_lo_in,
	input wire logic [7:0] imm_hi_in,
	// Register file values
	input wire logic [15:0] base_word_reg_in,
	input wire logic [15:0] base_pointer_reg_in,
	input wire logic [15:0] source_index_reg_in,
	input wire logic [15:0] dest_index_reg_in,
	input wire logic [7:0] count_low_byte_in,
	input wire logic [15:0] bit_operand_in,
	// Decode results
	output logic decode_valid_out,
	output class_t class_out,
	output logic word_op_out,
	output logic reg_is_dest_out,
	output logic has_modrm_out,
	output logic imm_sext_out,
	output logic [15:0] imm_word_out,
	output logic acc_dest_out,
	output logic [2:0] group_op_out,
	output logic [7:0] ext_op_out,
	output logic [2:0] reg_sel_out,
	output logic [1:0] seg_sel_out,
	output logic [3:0] cond_out,
	output logic port_indirect_out,
	output logic far_out,
	output logic undefined_out,
	// Operand address and bit operation results
	output logic [15:0] ea_out,
	output logic mem_operand_out,
	output logic bit_op_out,
	output logic [15:0] bit_result_out,
	output logic bit_test_out
);

	// ------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------

	// Opcodes followed by an operand specifier byte
	function automatic logic modrm_of(input logic [7:0] op);
		modrm_of = 1'b0;
		if (op[7:6] == 2'b00 && op[2] == 1'b0) modrm_of = 1'b1;
		if (op[7:4] == 4'h8) modrm_of = 1'b1;
		unique case (op)
			8'h62, 8'h69, 8'h6b, 8'hc0, 8'hc1, 8'hc4, 8'hc5,
			8'hc6, 8'hc7, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hf6,
			8'hf7, 8'hfe, 8'hff: modrm_of = 1'b1;
			default: ;
		endcase
		if (op == OP_ESCAPE) modrm_of = 1'b0;
	endfunction

	// Arithmetic and move forms carrying a direction bit
	function automatic logic dir_form(input logic [7:0] op);
		dir_form = (op[7:6] == 2'b00 && op[2] == 1'b0 && op != OP_ESCAPE)
			|| (op[7:2] == 6'b100010);
	endfunction

	// ------------------------------------------------------------
	// Combinational decode of the current bytes
	// ------------------------------------------------------------
	class_t next_class;
	logic [1:0] mode;
	logic [15:0] next_ea;
	logic next_mem;
	logic esc_bit;
	logic [15:0] next_bit_result;
	logic next_bit_test;
	logic next_sext;
	logic next_word;

	// Class from the shared row and column table
	assign next_class = class_of(first_byte_in);
	assign mode = second_byte_in[MOD_MSB:MOD_LSB];
	assign esc_bit = (first_byte_in == OP_ESCAPE)
		&& (second_byte_in[7:4] == ROW_BITOPS);
	assign next_sext = (first_byte_in[7:1] == 7'b1000001)
		|| (first_byte_in == 8'h6a) || (first_byte_in == 8'h6b);
	assign next_word = (first_byte_in[7:4] == 4'hb) ? first_byte_in[3]
		: (esc_bit ? second_byte_in[0] : first_byte_in[0]);

	// Operand address for specifier forms
	ea_adder u_ea (
		.mode_in(mode),
		.rm_in(second_byte_in[RM_MSB:RM_LSB]),
		.disp_lo_in(disp_lo_in),
		.disp_hi_in(disp_hi_in),
		.base_word_reg_in(base_word_reg_in),
		.base_pointer_reg_in(base_pointer_reg_in),
		.source_index_reg_in(source_index_reg_in),
		.dest_index_reg_in(dest_index_reg_in),
		.ea_out(next_ea),
		.is_mem_out(next_mem)
	);

	// Escape-group single-bit operations
	bit_op_unit u_bit (
		.op_in(second_byte_in[2:1]),
		.word_in(second_byte_in[0]),
		.use_count_in(~second_byte_in[3]),
		.imm_bits_in(imm_lo_in[3:0]),
		.count_low_byte_in(count_low_byte_in),
		.operand_in(bit_operand_in),
		.result_out(next_bit_result),
		.tested_out(next_bit_test)
	);

	// ------------------------------------------------------------
	// Registered results
	// ------------------------------------------------------------

	// Result strobe
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) decode_valid_out <= 1'b0;
		else decode_valid_out <= inst_valid_in;
	end

	// Class, size, direction and special flags
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			class_out <= CLS_NOP;
			word_op_out <= 1'b0;
			reg_is_dest_out <= 1'b0;
			has_modrm_out <= 1'b0;
			acc_dest_out <= 1'b0;
			port_indirect_out <= 1'b0;
			far_out <= 1'b0;
			undefined_out <= 1'b0;
		end else if (inst_valid_in) begin
			class_out <= next_class;
			word_op_out <= next_word;
			reg_is_dest_out <= dir_form(first_byte_in)
				&& first_byte_in[1];
			has_modrm_out <= modrm_of(first_byte_in);
			acc_dest_out <= (first_byte_in[7:6] == 2'b00
				&& first_byte_in[2:1] == 2'b10)
				|| first_byte_in[7:1] == 7'b1010100;
			port_indirect_out <= (first_byte_in[7:2] == 6'b111011);
			far_out <= first_byte_in == OP_FAR_CALL
				|| first_byte_in == OP_FAR_BR
				|| first_byte_in == OP_FAR_RET
				|| first_byte_in == OP_FAR_RET1
				|| (first_byte_in == OP_GRP2_W
				&& (second_byte_in[REG_MSB:REG_LSB] == GRP2_FAR_CALL
				|| second_byte_in[REG_MSB:REG_LSB] == GRP2_FAR_BR));
			undefined_out <= (next_class == CLS_UNDEF);
		end
	end

	// Immediate operand shaping
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			imm_sext_out <= 1'b0;
			imm_word_out <= 16'h0000;
		end else if (inst_valid_in) begin
			imm_sext_out <= next_sext;
			if (next_sext) imm_word_out <= {{8{imm_lo_in[7]}}, imm_lo_in};
			else if (next_word) imm_word_out <= {imm_hi_in, imm_lo_in};
			else imm_word_out <= {8'h00, imm_lo_in};
		end
	end

	// Sub-operation, register, segment and condition selects
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			group_op_out <= 3'h0;
			ext_op_out <= 8'h00;
			reg_sel_out <= 3'h0;
			seg_sel_out <= 2'h0;
			cond_out <= 4'h0;
		end else if (inst_valid_in) begin
			group_op_out <= second_byte_in[REG_MSB:REG_LSB];
			ext_op_out <= (first_byte_in == OP_ESCAPE) ? second_byte_in
				: 8'h00;
			if (modrm_of(first_byte_in)) begin
				reg_sel_out <= second_byte_in[REG_MSB:REG_LSB];
			end else begin
				reg_sel_out <= first_byte_in[2:0];
			end
			if (modrm_of(first_byte_in)) begin
				seg_sel_out <= second_byte_in[SREG_MSB:SREG_LSB];
			end else begin
				seg_sel_out <= first_byte_in[4:3];
			end
			cond_out <= first_byte_in[3:0];
		end
	end

	// Operand address and bit results
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ea_out <= 16'h0000;
			mem_operand_out <= 1'b0;
			bit_op_out <= 1'b0;
			bit_result_out <= 16'h0000;
			bit_test_out <= 1'b0;
		end else if (inst_valid_in) begin
			ea_out <= next_ea;
			mem_operand_out <= next_mem && modrm_of(first_byte_in);
			bit_op_out <= esc_bit;
			bit_result_out <= next_bit_result;
			bit_test_out <= next_bit_test;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	logic [15:0] exp_based;
	logic [15:0] opnd_q;
	assign exp_based = 16'(base_pointer_reg_in
		+ {{8{disp_lo_in[7]}}, disp_lo_in});

	// Operand copy for the unchanged-bits check
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) opnd_q <= 16'h0000;
		else opnd_q <= bit_operand_in;
	end

	// Named steps shared by the properties below
	sequence s_take(logic [7:0] op);
		inst_valid_in && first_byte_in == op;
	endsequence

	sequence s_based8;
		inst_valid_in && first_byte_in == 8'h8b
			&& mode == MOD_DISP8 && second_byte_in[2:0] == RM_DIRECT;
	endsequence

	a_nop_class: assert property (s_take(OP_NOP) |=> class_out == CLS_NOP)
		else $error("nop not decoded");
	a_undef_codes: assert property (inst_valid_in && (first_byte_in == 8'h63
		|| first_byte_in == 8'hd6 || first_byte_in == 8'hf1)
		|=> undefined_out && decode_valid_out)
		else $error("undefined code accepted");
	a_based_addr: assert property (s_based8 |=> ea_out == $past(exp_based))
		else $error("based address wrong");
	a_bits_kept: assert property (inst_valid_in && esc_bit
		|=> $countones(bit_result_out ^ opnd_q) <= 1)
		else $error("other bits changed");
	a_group_field: assert property (s_take(8'h80)
		|=> group_op_out == $past(second_byte_in[5:3]))
		else $error("group field wrong");
	a_escape_op: assert property (s_take(OP_ESCAPE)
		|=> class_out == CLS_ESCAPE && ext_op_out == $past(second_byte_in))
		else $error("escape op wrong");
	a_sext_imm: assert property (s_take(8'h83)
		|=> imm_word_out[15:8] == {8{imm_word_out[7]}} && imm_sext_out)
		else $error("immediate not extended");
	a_cond_field: assert property (inst_valid_in && first_byte_in[7:4] == 4'h7
		|=> class_out == CLS_BRCOND && cond_out == $past(first_byte_in[3:0]))
		else $error("condition field wrong");
	a_incdec_reg: assert property (inst_valid_in && first_byte_in[7:4] == 4'h4
		|=> reg_sel_out == $past(first_byte_in[2:0]))
		else $error("register select wrong");
	a_port_ind: assert property (inst_valid_in && first_byte_in[7:2] == 6'h3b
		|=> port_indirect_out)
		else $error("port source wrong");
	a_far_call: assert property (s_take(OP_FAR_CALL) |=> far_out)
		else $error("far form not flagged");
	a_acc_imm: assert property (s_take(8'h05) |=> acc_dest_out && word_op_out)
		else $error("accumulator form wrong");

endmodule

// ---- hw/decode_pkg.sv ----
// Shared constants and types for the native opcode decoder
package decode_pkg;

	// ------------------------------------------------------------
	// Instruction classes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		CLS_ALU = 5'h00,
		CLS_PUSH = 5'h01,
		CLS_POP = 5'h02,
		CLS_INCDEC = 5'h03,
		CLS_BRCOND = 5'h04,
		CLS_MOVIMM = 5'h05,
		CLS_NOP = 5'h06,
		CLS_XCH = 5'h07,
		CLS_IMMGRP = 5'h08,
		CLS_SHIFTGRP = 5'h09,
		CLS_UNARY1 = 5'h0a,
		CLS_UNARY2 = 5'h0b,
		CLS_ESCAPE = 5'h0c,
		CLS_IO = 5'h0d,
		CLS_CALL = 5'h0e,
		CLS_BRANCH = 5'h0f,
		CLS_RET = 5'h10,
		CLS_PREFIX = 5'h11,
		CLS_MOV = 5'h12,
		CLS_TEST = 5'h13,
		CLS_MISC = 5'h14,
		CLS_UNDEF = 5'h15
	} class_t;

	// ------------------------------------------------------------
	// Fixed opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ESCAPE = 8'h0f;
	localparam logic [7:0] OP_NOP = 8'h90;
	localparam logic [7:0] OP_UNDEF_A = 8'h63;
	localparam logic [7:0] OP_UNDEF_B = 8'hd6;
	localparam logic [7:0] OP_UNDEF_C = 8'hf1;
	localparam logic [7:0] OP_FAR_CALL = 8'h9a;
	localparam logic [7:0] OP_FAR_BR = 8'hea;
	localparam logic [7:0] OP_FAR_RET = 8'hca;
	localparam logic [7:0] OP_FAR_RET1 = 8'hcb;
	localparam logic [7:0] OP_GRP2_W = 8'hff;
	localparam logic [3:0] ROW_BITOPS = 4'h1;

	// ------------------------------------------------------------
	// Second byte field positions
	// ------------------------------------------------------------
	localparam int MOD_MSB = 7;
	localparam int MOD_LSB = 6;
	localparam int REG_MSB = 5;
	localparam int REG_LSB = 3;
	localparam int SREG_MSB = 4;
	localparam int SREG_LSB = 3;
	localparam int RM_MSB = 2;
	localparam int RM_LSB = 0;

	// ------------------------------------------------------------
	// Field values
	// ------------------------------------------------------------
	localparam logic [1:0] MOD_NODISP = 2'b00;
	localparam logic [1:0] MOD_DISP8 = 2'b01;
	localparam logic [1:0] MOD_DISP16 = 2'b10;
	localparam logic [1:0] MOD_REGISTER = 2'b11;
	localparam logic [2:0] RM_DIRECT = 3'b110;
	localparam logic [2:0] GRP2_FAR_CALL = 3'b011;
	localparam logic [2:0] GRP2_FAR_BR = 3'b101;

	// Single-bit operation codes
	localparam logic [1:0] BIT_TEST = 2'b00;
	localparam logic [1:0] BIT_CLEAR = 2'b01;
	localparam logic [1:0] BIT_SET = 2'b10;
	localparam logic [1:0] BIT_INVERT = 2'b11;

	// Bit-number field widths for byte and word operands
	localparam int BITNUM_BYTE_W = 3;
	localparam int BITNUM_WORD_W = 4;

	// ------------------------------------------------------------
	// Class decode
	// ------------------------------------------------------------

	// Class from row and column of the first byte
	function automatic class_t class_of(input logic [7:0] op);
		logic [3:0] row;
		logic [3:0] col;
		row = op[7:4];
		col = op[3:0];
		class_of = CLS_MISC;
		unique case (row)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				if (col[2:0] <= 3'd5) class_of = CLS_ALU;
				else if (op == OP_ESCAPE) class_of = CLS_ESCAPE;
				else if (row[1]) class_of = col[0] ? CLS_MISC : CLS_PREFIX;
				else class_of = col[0] ? CLS_POP : CLS_PUSH;
			end
			4'h4: class_of = CLS_INCDEC;
			4'h5: class_of = col[3] ? CLS_POP : CLS_PUSH;
			4'h6: begin
				unique case (col)
					4'h0, 4'h8, 4'ha: class_of = CLS_PUSH;
					4'h1: class_of = CLS_POP;
					4'h3: class_of = CLS_UNDEF;
					4'h4, 4'h5: class_of = CLS_PREFIX;
					4'hc, 4'hd, 4'he, 4'hf: class_of = CLS_IO;
					default: class_of = CLS_MISC;
				endcase
			end
			4'h7: class_of = CLS_BRCOND;
			4'h8: begin
				unique case (col)
					4'h0, 4'h1, 4'h2, 4'h3: class_of = CLS_IMMGRP;
					4'h4, 4'h5: class_of = CLS_TEST;
					4'h6, 4'h7: class_of = CLS_XCH;
					4'hd: class_of = CLS_MISC;
					4'hf: class_of = CLS_POP;
					default: class_of = CLS_MOV;
				endcase
			end
			4'h9: begin
				unique case (col)
					4'h0: class_of = CLS_NOP;
					4'h8, 4'h9, 4'hb, 4'he, 4'hf: class_of = CLS_MISC;
					4'ha: class_of = CLS_CALL;
					4'hc: class_of = CLS_PUSH;
					4'hd: class_of = CLS_POP;
					default: class_of = CLS_XCH;
				endcase
			end
			4'ha: begin
				if (col <= 4'h3) class_of = CLS_MOV;
				else if (col == 4'h8 || col == 4'h9) class_of = CLS_TEST;
				else class_of = CLS_MISC;
			end
			4'hb: class_of = CLS_MOVIMM;
			4'hc: begin
				unique case (col)
					4'h0, 4'h1: class_of = CLS_SHIFTGRP;
					4'h2, 4'h3, 4'ha, 4'hb, 4'hf: class_of = CLS_RET;
					4'h4, 4'h5, 4'h6, 4'h7: class_of = CLS_MOV;
					default: class_of = CLS_MISC;
				endcase
			end
			4'hd: begin
				if (col <= 4'h3) class_of = CLS_SHIFTGRP;
				else if (op == OP_UNDEF_B) class_of = CLS_UNDEF;
				else class_of = CLS_MISC;
			end
			4'he: begin
				unique case (col)
					4'h0, 4'h1, 4'h2, 4'h3: class_of = CLS_BRCOND;
					4'h8: class_of = CLS_CALL;
					4'h9, 4'ha, 4'hb: class_of = CLS_BRANCH;
					default: class_of = CLS_IO;
				endcase
			end
			4'hf: begin
				unique case (col)
					4'h0, 4'h2, 4'h3: class_of = CLS_PREFIX;
					4'h1: class_of = CLS_UNDEF;
					4'h6, 4'h7: class_of = CLS_UNARY1;
					4'he, 4'hf: class_of = CLS_UNARY2;
					default: class_of = CLS_MISC;
				endcase
			end
		endcase
	endfunction

endpackage

// ---- hw/ea_adder.sv ----
// Effective address adder for memory operand forms
`timescale 1ns/1ps
module ea_adder
	import decode_pkg::*;
(
	// Operand specifier
	input wire logic [1:0] mode_in,
	input wire logic [2:0] rm_in,
	input wire logic [7:0] disp_lo_in,
	input wire logic [7:0] disp_hi_in,
	// Address registers
	input wire logic [15:0] base_word_reg_in,
	input wire logic [15:0] base_pointer_reg_in,
	input wire logic [15:0] source_index_reg_in,
	input wire logic [15:0] dest_index_reg_in,
	// Result
	output logic [15:0] ea_out,
	output logic is_mem_out
);

	logic [15:0] disp;
	logic [15:0] base;
	logic [15:0] index;

	// Displacement by mode, byte form sign-extended
	always_comb begin
		unique case (mode_in)
			MOD_DISP8: disp = {{8{disp_lo_in[7]}}, disp_lo_in};
			MOD_DISP16: disp = {disp_hi_in, disp_lo_in};
			default: disp = 16'h0000;
		endcase
	end

	// Base and index selection
	always_comb begin
		base = 16'h0000;
		index = 16'h0000;
		unique case (rm_in)
			3'b000: begin
				base = base_word_reg_in;
				index = source_index_reg_in;
			end
			3'b001: begin
				base = base_word_reg_in;
				index = dest_index_reg_in;
			end
			3'b010: begin
				base = base_pointer_reg_in;
				index = source_index_reg_in;
			end
			3'b011: begin
				base = base_pointer_reg_in;
				index = dest_index_reg_in;
			end
			3'b100: index = source_index_reg_in;
			3'b101: index = dest_index_reg_in;
			3'b110: begin
				// Direct address when no displacement mode
				if (mode_in != MOD_NODISP) begin
					base = base_pointer_reg_in;
				end
			end
			3'b111: base = base_word_reg_in;
		endcase
	end

	// Sum wraps at 16 bits before relocation
	always_comb begin
		if (mode_in == MOD_NODISP && rm_in == RM_DIRECT) begin
			ea_out = {disp_hi_in, disp_lo_in};
		end else begin
			ea_out = 16'(base + index + disp);
		end
		is_mem_out = (mode_in != MOD_REGISTER);
	end

endmodule

// ---- hw/bit_op_unit.sv ----
// Single-bit test, set, clear and invert on a byte or word
`timescale 1ns/1ps
module bit_op_unit
	import decode_pkg::*;
(
	// Operation
	input wire logic [1:0] op_in,
	input wire logic word_in,
	input wire logic use_count_in,
	// Bit number sources
	input wire logic [3:0] imm_bits_in,
	input wire logic [7:0] count_low_byte_in,
	// Operand and result
	input wire logic [15:0] operand_in,
	output logic [15:0] result_out,
	output logic tested_out
);

	logic [3:0] raw;
	logic [3:0] bitnum;
	logic [15:0] mask;

	// Bit number from immediate or count register, width by size
	always_comb begin
		raw = use_count_in ? count_low_byte_in[3:0] : imm_bits_in;
		if (word_in) begin
			bitnum = raw[BITNUM_WORD_W-1:0];
		end else begin
			bitnum = {1'b0, raw[BITNUM_BYTE_W-1:0]};
		end
		mask = 16'h0001 << bitnum;
	end

	// Only the selected bit may change
	always_comb begin
		tested_out = |(operand_in & mask);
		unique case (op_in)
			BIT_TEST: result_out = operand_in;
			BIT_CLEAR: result_out = operand_in & ~mask;
			BIT_SET: result_out = operand_in | mask;
			BIT_INVERT: result_out = operand_in ^ mask;
		endcase
	end

endmodule

// ---- testbench/regfile_model.sv ----
// Register file model standing in for the execution datapath
`timescale 1ns/1ps
module regfile_model (
	// Clock and write port
	input wire logic clk_sys_in,
	input wire logic wr_en_in,
	input wire logic [2:0] wr_sel_in,
	input wire logic [15:0] wr_data_in,
	// Register values seen by the decoder
	output logic [15:0] base_word_out = 16'h0000,
	output logic [15:0] base_ptr_out = 16'h0000,
	output logic [15:0] src_index_out = 16'h0000,
	output logic [15:0] dst_index_out = 16'h0000,
	output logic [7:0] count_out = 8'h00,
	output logic [15:0] operand_out = 16'h0000
);
	// One register written per edge, others hold
	always @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			case (wr_sel_in)
				3'h0: base_word_out <= wr_data_in;
				3'h1: base_ptr_out <= wr_data_in;
				3'h2: src_index_out <= wr_data_in;
				3'h3: dst_index_out <= wr_data_in;
				3'h4: count_out <= wr_data_in[7:0];
				default: operand_out <= wr_data_in;
			endcase
		end
	end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the native opcode decoder
`timescale 1ns/1ps
module testbench;
	import decode_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic inst_valid_in = 1'b0;
	logic [7:0] first_byte_in = 8'h00, second_byte_in = 8'h00;
	logic [7:0] disp_lo_in = 8'h00, disp_hi_in = 8'h00;
	logic [7:0] imm_lo_in = 8'h00, imm_hi_in = 8'h00;
	logic wr_en = 1'b0;
	logic [2:0] wr_sel = 3'h0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] base_word_reg_in, base_pointer_reg_in, bit_operand_in;
	logic [15:0] source_index_reg_in, dest_index_reg_in;
	logic [7:0] count_low_byte_in;
	logic decode_valid_out, word_op_out, reg_is_dest_out, has_modrm_out;
	logic imm_sext_out, acc_dest_out, port_indirect_out, far_out;
	logic undefined_out, mem_operand_out, bit_op_out, bit_test_out;
	class_t class_out;
	logic [15:0] imm_word_out, ea_out, bit_result_out;
	logic [2:0] group_op_out, reg_sel_out;
	logic [7:0] ext_op_out;
	logic [1:0] seg_sel_out;
	logic [3:0] cond_out;
	int bad_count = 0;
	int checks_done = 0;

	// Clock, 20 ns period
	always #10 clk_sys_in = ~clk_sys_in;

	opcode_decoder i_dut (.clk_sys_in, .reset_in, .inst_valid_in,
		.first_byte_in, .second_byte_in, .disp_lo_in, .disp_hi_in,
		.imm_lo_in, .imm_hi_in, .base_word_reg_in, .base_pointer_reg_in,
		.source_index_reg_in, .dest_index_reg_in, .count_low_byte_in,
		.bit_operand_in, .decode_valid_out, .class_out, .word_op_out,
		.reg_is_dest_out, .has_modrm_out, .imm_sext_out, .imm_word_out,
		.acc_dest_out, .group_op_out, .ext_op_out, .reg_sel_out,
		.seg_sel_out, .cond_out, .port_indirect_out, .far_out,
		.undefined_out, .ea_out, .mem_operand_out, .bit_op_out,
		.bit_result_out, .bit_test_out);

	regfile_model i_regs (.clk_sys_in, .wr_en_in(wr_en),
		.wr_sel_in(wr_sel), .wr_data_in(wr_data),
		.base_word_out(base_word_reg_in), .base_ptr_out(base_pointer_reg_in),
		.src_index_out(source_index_reg_in),
		.dst_index_out(dest_index_reg_in),
		.count_out(count_low_byte_in), .operand_out(bit_operand_in));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic final_report();
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic setreg(input logic [2:0] s, input logic [15:0] v);
		@(posedge clk_sys_in);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_data <= v;
		@(posedge clk_sys_in);
		wr_en <= 1'b0;
	endtask

	// One instruction, answer checked one edge later
	task automatic issue(input logic [7:0] a, b, c = 0, d = 0, e = 0,
		f = 0);
		@(posedge clk_sys_in);
		inst_valid_in <= 1'b1;
		first_byte_in <= a;
		second_byte_in <= b;
		disp_lo_in <= c;
		disp_hi_in <= d;
		imm_lo_in <= e;
		imm_hi_in <= f;
		@(posedge clk_sys_in);
		inst_valid_in <= 1'b0;
		#1 chk(16'(decode_valid_out), 16'h0001);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_based();
		setreg(3'h1, 16'h1000);
		issue(8'h8b, 8'h46, 8'hfe);
		chk(ea_out, 16'h0ffe);
		chk(16'(class_out), 16'(CLS_MOV));
		chk(16'(reg_is_dest_out), 16'h0001);
		chk(16'(has_modrm_out), 16'h0001);
		chk(16'(mem_operand_out), 16'h0001);
		setreg(3'h0, 16'hf000);
		issue(8'h8b, 8'h87, 8'h34, 8'h12);
		chk(ea_out, 16'h0234);
		@(posedge clk_sys_in);
		#1 chk(16'(decode_valid_out), 16'h0000);
		chk(ea_out, 16'h0234);
	endtask

	task automatic t_indexed();
		setreg(3'h0, 16'h0100);
		setreg(3'h2, 16'h0010);
		issue(8'h8b, 8'h40, 8'h80);
		chk(ea_out, 16'h0090);
		setreg(3'h1, 16'h2000);
		setreg(3'h3, 16'h0003);
		issue(8'h8b, 8'h03);
		chk(ea_out, 16'h2003);
	endtask

	task automatic t_bits();
		logic [15:0] e;
		logic [3:0] n;
		logic t;
		setreg(3'h5, 16'h8421);
		setreg(3'h4, 16'h00fa);
		for (int k = 0; k < 16; k++) begin
			n = k[3] ? (k[0] ? 4'hf : 4'h7) : (k[0] ? 4'ha : 4'h2);
			issue(8'h0f, {4'h1, k[3:0]}, 8'h00, 8'h00, 8'h1f);
			e = 16'h8421;
			t = e[n];
			case (k[2:1])
				BIT_SET: e[n] = 1'b1;
				BIT_CLEAR: e[n] = 1'b0;
				BIT_INVERT: e[n] = ~e[n];
				default: e = e;
			endcase
			chk(bit_result_out, e);
			chk(16'(bit_test_out), 16'(t));
			chk(16'(bit_op_out), 16'h0001);
			chk(16'(ext_op_out), {12'h001, k[3:0]});
		end
	endtask

	task automatic t_groups();
		logic [7:0] ops[4] = '{8'h80, 8'hc0, 8'hf6, 8'hfe};
		class_t cl[4] = '{CLS_IMMGRP, CLS_SHIFTGRP, CLS_UNARY1, CLS_UNARY2};
		for (int k = 0; k < 4; k++) begin
			issue(ops[k], 8'h28);
			chk(16'(class_out), 16'(cl[k]));
			chk(16'(group_op_out), 16'h0005);
		end
		issue(8'h0f, 8'he0);
		chk(16'(class_out), 16'(CLS_ESCAPE));
		chk(16'(ext_op_out), 16'h00e0);
		chk(16'(bit_op_out), 16'h0000);
		issue(8'h90, 8'he0);
		chk(16'(class_out), 16'(CLS_NOP));
		chk(16'(has_modrm_out), 16'h0000);
	endtask

	task automatic t_operands();
		issue(8'h83, 8'hc0, 8'h00, 8'h00, 8'h80, 8'h12);
		chk(imm_word_out, 16'hff80);
		chk(16'(imm_sext_out), 16'h0001);
		issue(8'h82, 8'hc0, 8'h00, 8'h00, 8'hfe);
		chk(imm_word_out, 16'hfffe);
		issue(8'h05, 8'h00, 8'h00, 8'h00, 8'h34, 8'h12);
		chk(16'(acc_dest_out), 16'h0001);
		chk(imm_word_out, 16'h1234);
		issue(8'h00, 8'h00);
		chk(16'(acc_dest_out), 16'h0000);
		chk(16'(reg_is_dest_out), 16'h0000);
		issue(8'hec, 8'h00);
		chk(16'(port_indirect_out), 16'h0001);
		issue(8'he4, 8'h00);
		chk(16'(port_indirect_out), 16'h0000);
		issue(8'h8c, 8'h18);
		chk(16'(seg_sel_out), 16'h0003);
		chk(16'(reg_sel_out), 16'h0003);
	endtask

	task automatic t_rows();
		for (int k = 0; k < 16; k++) begin
			issue(8'h40 | 8'(k), 8'h00);
			chk(16'(reg_sel_out), 16'(k % 8));
			chk(16'(class_out), 16'(CLS_INCDEC));
			issue(8'h50 | 8'(k), 8'h00);
			chk(16'(class_out), 16'(k < 8 ? CLS_PUSH : CLS_POP));
			issue(8'hb0 | 8'(k), 8'h00);
			chk(16'(word_op_out), 16'(k / 8));
			chk(16'(reg_sel_out), 16'(k % 8));
			issue(8'h70 | 8'(k), 8'h00);
			chk(16'(cond_out), 16'(k));
			chk(16'(class_out), 16'(CLS_BRCOND));
		end
	endtask

	task automatic t_special();
		logic [7:0] und[3] = '{OP_UNDEF_A, OP_UNDEF_B, OP_UNDEF_C};
		logic [7:0] far[6] = '{8'h9a, 8'hea, 8'hca, 8'hcb, 8'hff, 8'hff};
		logic [7:0] sec[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h28};
		for (int k = 0; k < 3; k++) begin
			issue(und[k], 8'h00);
			chk(16'(undefined_out), 16'h0001);
		end
		issue(8'h62, 8'h00);
		chk(16'(undefined_out), 16'h0000);
		for (int k = 0; k < 6; k++) begin
			issue(far[k], sec[k]);
			chk(16'(far_out), 16'h0001);
		end
		issue(8'hff, 8'h10);
		chk(16'(far_out), 16'h0000);
		issue(8'hc3, 8'h00);
		chk(16'(far_out), 16'h0000);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		#1 chk(16'(class_out), 16'(CLS_NOP));
		t_based();
		t_indexed();
		t_bits();
		t_groups();
		t_operands();
		t_rows();
		t_special();
		final_report();
	end

	// Cut a hang short
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
endmodule
